// file: core/acss_defines.vh
// register map, field layout and reset values of the converter channel select block
// assumes a 32-bit apb slave with 12-bit byte addresses, one register per aligned word
`ifndef ACSS_DEFINES_VH
`define ACSS_DEFINES_VH
// address width and byte offsets
`define ACSS_ADDR_W 12
`define ACSS_OFF_SAMPLE 12'h000
`define ACSS_OFF_BANDGAP 12'h004
`define ACSS_OFF_HIT_HI 12'h008
`define ACSS_OFF_HIT_LO 12'h00C
`define ACSS_OFF_SCAN_HI 12'h010
`define ACSS_OFF_SCAN_LO 12'h014
`define ACSS_OFF_CONTROL 12'h018
`define ACSS_OFF_IRQ_STAT 12'h01C
`define ACSS_OFF_IRQ_MASK 12'h020
// sample select field positions
`define ACSS_B_NEG_HI 15
`define ACSS_B_NEG_LO 13
`define ACSS_B_POS_HI 12
`define ACSS_B_POS_LO 8
`define ACSS_A_NEG_HI 7
`define ACSS_A_NEG_LO 5
`define ACSS_A_POS_HI 4
`define ACSS_A_POS_LO 0
// band gap enable bit positions
`define ACSS_BG_SIXTH 2
`define ACSS_BG_HALF 1
`define ACSS_BG_FULL 0
// implemented-bit masks of the register words
`define ACSS_MASK_BANDGAP 16'h0007
`define ACSS_MASK_HIT_HI 16'h03FF
`define ACSS_MASK_SCAN_HI 16'h7FFF
`define ACSS_MASK_IRQ 16'h0007
// positive select codes of the internal band gap inputs
`define ACSS_CODE_BG_FULL 5'h1C
`define ACSS_CODE_BG_HALF 5'h1B
`define ACSS_CODE_BG_SIXTH 5'h1A
// channel count of buffered channels, and the number of the last scanned channel
`define ACSS_HIT_CHANNELS 26
`define ACSS_LAST_SCAN_CH 5'h1E
// compare mode value meaning write-or-match
`define ACSS_CM_WRITE_OR_MATCH 2'h3
// interrupt status bit positions
`define ACSS_IRQ_HIT 0
`define ACSS_IRQ_SCAN_DONE 1
`define ACSS_IRQ_NO_BUFFER 2
// reset value of every register
`define ACSS_RESET_WORD 16'h0000
`endif

// file: core/acss_regs.v
// channel select, band gap enable, compare hit and scan select registers
// assumes an apb master on the same clock and a conversion core on the same clock
// assumes the conversion core answers each request with a one-cycle done pulse
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`include "acss_defines.vh"

module acss_regs (
   input wire clock,
   input wire reset,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // analog multiplexer and reference controls
   output reg [4:0] muxPositiveSelect,
   output reg [2:0] muxNegativeSelect,
   output wire bandgapFullEnable,
   output wire bandgapHalfEnable,
   output wire bandgapSixthEnable,
   // scan sequencer towards the conversion core
   input wire scanStart,
   input wire convDone,
   output wire convRequest,
   output wire [4:0] convChannel,
   output wire scanBusy,
   // results coming back from the conversion core
   input wire resultValid,
   input wire [4:0] resultChannel,
   input wire compareMatch,
   output reg bufferWrite,
   output reg [4:0] bufferChannel,
   // interrupt
   output wire irq
);

   // sequencer states
   localparam ST_IDLE = 2'h0;
   localparam ST_FIND = 2'h1;
   localparam ST_CONV = 2'h2;

   // storage is kept at implemented widths only, so unimplemented bits
   // can never hold a stale one and always read back as zero
   // register storage
   reg [15:0] sampleSel_q; // both sample fields
   reg [2:0] bandgap_q; // reference enables
   reg [25:0] hit_q; // compare hit flags
   reg [25:0] hit_d;
   reg [30:0] scanBits_q; // scan include bits
   reg [1:0] compareMode_q; // compare mode field
   reg [2:0] irqStat_q; // sticky events
   reg [2:0] irqStat_d;
   reg [2:0] irqMask_q; // interrupt enables
   reg [1:0] state_q; // sequencer state
   reg [1:0] state_d;
   reg [4:0] scanIdx_q; // channel under scan
   reg [4:0] scanIdx_d;

   // all twelve address bits are decoded; an alias would let a stray
   // pointer move the multiplexer without raising an error
   // bus decode helpers
   wire setupPhase;
   wire writeAccess;
   wire [15:0] wrMask; // byte lanes as bit mask
   wire [15:0] wrData;
   reg [15:0] rdWord;
   reg rdHit; // address is mapped

   // codes 26 and up pick band gap taps and supply monitors; none of
   // them owns a result slot, so they may only raise a status bit
   // event helpers
   wire resultInternal; // code without buffer slot
   wire resultBuffered;
   wire hitCause;
   wire [25:0] hitSet;
   wire scanDone;

   // no wait states: the access phase always completes
   assign pready = psel & penable;
   assign setupPhase = psel & ~penable;
   assign writeAccess = psel & penable & pwrite;
   assign wrMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   assign wrData = pwdata[15:0];

   // read multiplexer; unimplemented bits are padded with zero
   // the decode looks at paddr alone, so the word is ready in the setup
   // cycle and the access cycle only has to return it
   always @* begin
      rdHit = 1'b1;
      rdWord = `ACSS_RESET_WORD;
      case (paddr)
         `ACSS_OFF_SAMPLE: begin
            // both sample fields, all sixteen bits implemented
            rdWord = sampleSel_q;
         end
         `ACSS_OFF_BANDGAP: begin
            // three enables, upper bits read zero
            rdWord = {13'h0000, bandgap_q};
         end
         `ACSS_OFF_HIT_HI: begin
            // flags of channels 25..16
            rdWord = {6'h00, hit_q[25:16]};
         end
         `ACSS_OFF_HIT_LO: begin
            // flags of channels 15..0
            rdWord = hit_q[15:0];
         end
         `ACSS_OFF_SCAN_HI: begin
            // include bits of channels 30..16
            rdWord = {1'b0, scanBits_q[30:16]};
         end
         `ACSS_OFF_SCAN_LO: begin
            // include bits of channels 15..0
            rdWord = scanBits_q[15:0];
         end
         `ACSS_OFF_CONTROL: begin
            // compare mode field only
            rdWord = {14'h0000, compareMode_q};
         end
         `ACSS_OFF_IRQ_STAT: begin
            // pending events
            rdWord = {13'h0000, irqStat_q};
         end
         `ACSS_OFF_IRQ_MASK: begin
            // event enables
            rdWord = {13'h0000, irqMask_q};
         end
         default: begin
            // unmapped word answers zero with an error
            rdHit = 1'b0;
         end
      endcase
   end

   // read data and error are captured in the setup cycle so they come from flops;
   // a flag set during the access cycle shows on the next read, never lost
   // pslverr uses the same decode and keeps its value until the next setup cycle
   always @(posedge clock) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setupPhase) begin
         prdata <= {16'h0000, rdWord};
         pslverr <= ~rdHit;
      end
   end

   // internal codes are the band gap taps and everything above them
   assign resultInternal = (resultChannel >= `ACSS_CODE_BG_SIXTH);
   assign resultBuffered = resultValid & ~resultInternal;
   // mode 11 counts any buffer write; other modes count matches only
   assign hitCause = (compareMode_q == `ACSS_CM_WRITE_OR_MATCH) ? 1'b1 : compareMatch;
   assign hitSet = (resultBuffered & hitCause) ? (26'h000_0001 << resultChannel) : 26'h000_0000;

   // hit flags: software writes zero to clear, ones are ignored, hardware set wins
   // clear first, then set, so a result landing in the clearing cycle
   // is not lost; software sees it on its next read
   always @* begin
      hit_d = hit_q;
      if (writeAccess && paddr == `ACSS_OFF_HIT_LO) begin
         // low word covers channels 15..0
         hit_d[15:0] = hit_q[15:0] & ~(wrMask & ~wrData);
      end
      if (writeAccess && paddr == `ACSS_OFF_HIT_HI) begin
         // high word covers channels 25..16
         hit_d[25:16] = hit_q[25:16] & ~(wrMask[9:0] & ~wrData[9:0]);
      end
      hit_d = hit_d | hitSet;
   end

   // interrupt status: write one to clear, a new event in the same cycle wins
   // events are taken before the mask, so masking hides but never loses them
   always @* begin
      irqStat_d = irqStat_q;
      if (writeAccess && paddr == `ACSS_OFF_IRQ_STAT && pstrb[0]) begin
         // write one to clear
         irqStat_d = irqStat_q & ~wrData[2:0];
      end
      if (|hitSet) begin
         // any new hit flag
         irqStat_d[`ACSS_IRQ_HIT] = 1'b1;
      end
      if (scanDone) begin
         // sequencer returned to idle
         irqStat_d[`ACSS_IRQ_SCAN_DONE] = 1'b1;
      end
      if (resultValid && resultInternal) begin
         // result on a channel without a slot
         irqStat_d[`ACSS_IRQ_NO_BUFFER] = 1'b1;
      end
   end

   // level interrupt while any enabled event is pending
   // a masked event stays pending and raises irq once unmasked
   assign irq = |(irqStat_q & irqMask_q);

   // software-writable registers with byte lanes
   always @(posedge clock) begin
      if (reset) begin
         // every implemented bit starts at zero
         sampleSel_q <= `ACSS_RESET_WORD;
         bandgap_q <= 3'h0;
         hit_q <= 26'h000_0000;
         scanBits_q <= 31'h0000_0000;
         compareMode_q <= 2'h0;
         irqStat_q <= 3'h0;
         irqMask_q <= 3'h0;
      end else begin
         // hit and status words take their next value on every edge
         hit_q <= hit_d;
         irqStat_q <= irqStat_d;
         if (writeAccess) begin
            case (paddr)
               `ACSS_OFF_SAMPLE: begin
                  // both sample a fields share this word with sample b
                  sampleSel_q <= (sampleSel_q & ~wrMask) | (wrData & wrMask);
               end
               `ACSS_OFF_BANDGAP: begin
                  if (pstrb[0]) begin
                     // the enables sit in the low lane
                     bandgap_q <= wrData[2:0];
                  end
               end
               `ACSS_OFF_SCAN_HI: begin
                  // bit 15 has no storage
                  scanBits_q[30:16] <= (scanBits_q[30:16] & ~wrMask[14:0]) | (wrData[14:0] & wrMask[14:0]);
               end
               `ACSS_OFF_SCAN_LO: begin
                  // one include bit per channel
                  scanBits_q[15:0] <= (scanBits_q[15:0] & ~wrMask) | (wrData & wrMask);
               end
               `ACSS_OFF_CONTROL: begin
                  if (pstrb[0]) begin
                     // applies from the next result on
                     compareMode_q <= wrData[1:0];
                  end
               end
               `ACSS_OFF_IRQ_MASK: begin
                  if (pstrb[0]) begin
                     // masking never clears a pending event
                     irqMask_q <= wrData[2:0];
                  end
               end
               default: begin
                  // hit and status words are handled above; others ignored
               end
            endcase
         end
      end
   end

   // reference enables drive the analog taps directly
   // they are not gated by the scan; software owns the taps
   assign bandgapSixthEnable = bandgap_q[`ACSS_BG_SIXTH];
   assign bandgapHalfEnable = bandgap_q[`ACSS_BG_HALF];
   assign bandgapFullEnable = bandgap_q[`ACSS_BG_FULL];

   // scan sequencer next state: walk channels 0..30, converting only included ones
   // a scan cannot be stopped by software; clearing the include bits
   // mid-scan only makes the remaining channels skip
   always @* begin
      state_d = state_q;
      scanIdx_d = scanIdx_q;
      case (state_q)
         ST_IDLE: begin
            // a start with no channel included is ignored
            if (scanStart && |scanBits_q) begin
               state_d = ST_FIND;
               scanIdx_d = 5'h00;
            end
         end
         ST_FIND: begin
            if (scanBits_q[scanIdx_q]) begin
               // included: convert it
               state_d = ST_CONV;
            end else if (scanIdx_q == `ACSS_LAST_SCAN_CH) begin
               // last channel passed: scan over
               state_d = ST_IDLE;
            end else begin
               // a skipped channel costs one cycle
               scanIdx_d = scanIdx_q + 5'h01;
            end
         end
         ST_CONV: begin
            // hold the request until the core reports the conversion done
            if (convDone) begin
               if (scanIdx_q == `ACSS_LAST_SCAN_CH) begin
                  // last channel converted
                  state_d = ST_IDLE;
               end else begin
                  // resume the search at the next channel
                  state_d = ST_FIND;
                  scanIdx_d = scanIdx_q + 5'h01;
               end
            end
         end
         default: begin
            // unused state code recovers to idle
            state_d = ST_IDLE;
         end
      endcase
   end

   // scan finishes when the last channel is passed or converted
   // a one-cycle pulse, taken only by the status word
   assign scanDone = (state_q != ST_IDLE) && (state_d == ST_IDLE);

   // sequencer state registers
   always @(posedge clock) begin
      if (reset) begin
         // start idle at channel zero
         state_q <= ST_IDLE;
         scanIdx_q <= 5'h00;
      end else begin
         state_q <= state_d;
         scanIdx_q <= scanIdx_d;
      end
   end

   // sequencer outputs come straight from its state flops
   assign convRequest = (state_q == ST_CONV);
   assign convChannel = scanIdx_q;
   assign scanBusy = (state_q != ST_IDLE);

   // positive select: the scan channel while scanning, else sample a; negative select always sample a;
   // the sample b fields are only stored, alternate sampling lives elsewhere
   always @(posedge clock) begin
      if (reset) begin
         muxPositiveSelect <= 5'h00;
         muxNegativeSelect <= 3'h0;
      end else begin
         if (state_q != ST_IDLE) begin
            // the sequencer owns the input while busy
            muxPositiveSelect <= scanIdx_q;
         end else begin
            // manual sampling uses the sample a code
            muxPositiveSelect <= sampleSel_q[`ACSS_A_POS_HI:`ACSS_A_POS_LO];
         end
         muxNegativeSelect <= sampleSel_q[`ACSS_A_NEG_HI:`ACSS_A_NEG_LO];
      end
   end

   // buffer write strobe: internal band gap codes have no slot, so no strobe
   // the channel travels with the strobe so the slot index lines up with it;
   // while the strobe is low the channel is of no meaning
   always @(posedge clock) begin
      if (reset) begin
         bufferWrite <= 1'b0;
         bufferChannel <= 5'h00;
      end else begin
         bufferWrite <= resultBuffered;
         bufferChannel <= resultChannel;
      end
   end

endmodule

// file: bench/acss_regs_monitor.sv
// port checker for the channel select register block
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/100ps
module acss_regs_monitor (
   input wire clock,
   input wire reset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire resultValid,
   input wire [4:0] resultChannel,
   input wire bufferWrite,
   input wire [4:0] bufferChannel,
   input wire convRequest,
   input wire convDone,
   input wire [4:0] convChannel,
   input wire scanBusy,
   input wire bandgapFullEnable,
   input wire bandgapHalfEnable,
   input wire bandgapSixthEnable,
   input wire irq
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   // buffered channels get exactly one slot write, on the next cycle
   AST_BUF_SLOT: assert property (resultValid && resultChannel < 5'h1A |=>
      bufferWrite && bufferChannel == $past(resultChannel)) else $error("buffer slot write missing");
   AST_NO_SLOT: assert property (resultValid && resultChannel >= 5'h1A |=> !bufferWrite)
      else $error("internal channel wrote a slot");
   AST_NO_SPURIOUS: assert property (!resultValid |=> !bufferWrite) else $error("slot write without result");
   // a request holds its channel until the core answers
   AST_REQ_HOLD: assert property (convRequest && !convDone |=> convRequest && $stable(convChannel))
      else $error("request dropped early");
   AST_REQ_END: assert property (convRequest && convDone |=> !convRequest) else $error("request outlived done");
   AST_REQ_BUSY: assert property (convRequest |-> scanBusy) else $error("request outside scan");
   AST_SCAN_RANGE: assert property (convRequest |-> convChannel <= 5'h1E) else $error("channel above 30");
   // reference enables move only on a register write
   AST_BG_HOLD: assert property (!(psel && penable && pwrite) |=>
      $stable({bandgapFullEnable, bandgapHalfEnable, bandgapSixthEnable})) else $error("enable moved alone");
   cover property (convRequest && convDone && convChannel == 5'h1E);
   cover property (bufferWrite);
   cover property (irq);
endmodule

bind acss_regs acss_regs_monitor u_mon (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .resultValid(resultValid), .resultChannel(resultChannel), .bufferWrite(bufferWrite),
   .bufferChannel(bufferChannel), .convRequest(convRequest), .convDone(convDone), .convChannel(convChannel),
   .scanBusy(scanBusy), .bandgapFullEnable(bandgapFullEnable), .bandgapHalfEnable(bandgapHalfEnable),
   .bandgapSixthEnable(bandgapSixthEnable), .irq(irq));

// file: bench/acss_conv_model.sv
// conversion core stand-in: answers each request after a chosen latency
// assumes the sequencer holds its request until it sees done
`timescale 1ns/100ps
module acss_conv_model (
   input wire clock,
   input wire reset,
   input wire convRequest,
   input wire [4:0] convChannel,
   input wire [3:0] latency,
   input wire [30:0] matchMask,
   output reg convDone = 1'b0,
   output reg resultValid = 1'b0,
   output reg [4:0] resultChannel = 5'h00,
   output reg compareMatch = 1'b0
);
   reg [3:0] waitCnt_q = 4'h0; // cycles spent on the current request
   // idle result lines toggle so a stale value never passes for a fresh one
   always @(posedge clock) begin
      convDone <= 1'b0;
      resultValid <= 1'b0;
      resultChannel <= ~resultChannel;
      compareMatch <= ~compareMatch;
      if (reset || !convRequest || convDone) begin
         waitCnt_q <= 4'h0;
      end else if (waitCnt_q == latency) begin
         convDone <= 1'b1;
         resultValid <= 1'b1;
         resultChannel <= convChannel;
         compareMatch <= matchMask[convChannel];
      end else begin
         waitCnt_q <= waitCnt_q + 4'h1;
      end
   end
endmodule

// file: bench/acss_regs_tb.sv
// self-checking bench for the channel select registers
// assumes the design and the conversion core model are compiled alongside
`timescale 1ns/100ps
`include "acss_defines.vh"
module acss_regs_tb;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, scanStart = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic [3:0] latency = 4'h0;
   logic [30:0] matchMask = 31'h0000_0004; // only channel 2 matches
   wire pready, pslverr, bgFull, bgHalf, bgSixth, convDone, convRequest, scanBusy;
   wire resultValid, compareMatch, bufferWrite, irq;
   wire [31:0] prdata;
   wire [4:0] muxPos, convChannel, resultChannel, bufferChannel;
   wire [2:0] muxNeg;
   int fail_count = 0, compares = 0, bufCount = 0;
   logic [4:0] seenCh[$];
   logic [4:0] slotCh[$];
   logic [4:0] expCh[5] = '{5'h00, 5'h02, 5'h19, 5'h1A, 5'h1E};
   logic [31:0] rdData;
   logic rdErr;
   logic [4:0] codes[3] = '{5'h1C, 5'h1B, 5'h1A};

   acss_regs dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .muxPositiveSelect(muxPos), .muxNegativeSelect(muxNeg), .bandgapFullEnable(bgFull),
      .bandgapHalfEnable(bgHalf), .bandgapSixthEnable(bgSixth), .scanStart(scanStart), .convDone(convDone),
      .convRequest(convRequest), .convChannel(convChannel), .scanBusy(scanBusy), .resultValid(resultValid),
      .resultChannel(resultChannel), .compareMatch(compareMatch), .bufferWrite(bufferWrite),
      .bufferChannel(bufferChannel), .irq(irq));
   acss_conv_model core (.clock(clock), .reset(reset), .convRequest(convRequest), .convChannel(convChannel),
      .latency(latency), .matchMask(matchMask), .convDone(convDone), .resultValid(resultValid),
      .resultChannel(resultChannel), .compareMatch(compareMatch));

   // 250 MHz clock
   initial begin
      forever #2 clock = ~clock;
   end
   // record converted channels and slot writes
   always @(posedge clock) begin
      if (convRequest === 1'b1 && convDone === 1'b1) seenCh.push_back(convChannel);
      if (bufferWrite === 1'b1) begin
         bufCount++;
         slotCh.push_back(bufferChannel);
      end
   end

   task automatic close_out;
      $display("mismatches %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer; the wait for pready is bounded
   task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fail_count++;
         close_out;
      end
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 16'h0000, 4'hF);
      chk("register read", rdData, e);
   endtask
   // one full scan; collected channels are compared with expCh
   task automatic scan;
      int n;
      n = 0;
      seenCh.delete();
      slotCh.delete();
      bufCount = 0;
      @(posedge clock);
      scanStart <= 1'b1;
      @(posedge clock);
      scanStart <= 1'b0;
      do begin
         @(posedge clock);
         n++;
      end while (scanBusy !== 1'b0 && n < 2000);
      if (scanBusy !== 1'b0) begin
         fail_count++;
         close_out;
      end
      #1;
      chk("scan count", seenCh.size(), 32'h0000_0005);
      foreach (expCh[i]) chk("scan channel", 32'(seenCh[i]), 32'(expCh[i]));
      chk("slot writes", bufCount, 32'h0000_0003);
      for (int i = 0; i < 3; i++) chk("slot channel", 32'(slotCh[i]), 32'(expCh[i]));
   endtask

   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      for (int i = 0; i < 9; i++) rd(12'(i * 4), 32'h0000_0000);
      chk("unmapped error", {31'h0000_0000, rdErr}, 32'h0000_0000);
      rd(12'h024, 32'h0000_0000);
      chk("unmapped error", {31'h0000_0000, rdErr}, 32'h0000_0001);
      // sample A fields reach the multiplexer
      xfer(1'b1, `ACSS_OFF_SAMPLE, 16'hA5C3, 4'hF);
      rd(`ACSS_OFF_SAMPLE, 32'h0000_A5C3);
      chk("negative select", 32'(muxNeg), 32'h0000_0006);
      chk("positive select", 32'(muxPos), 32'h0000_0003);
      xfer(1'b1, `ACSS_OFF_SAMPLE, 16'h0000, 4'h2);
      rd(`ACSS_OFF_SAMPLE, 32'h0000_00C3);
      foreach (codes[i]) begin
         xfer(1'b1, `ACSS_OFF_SAMPLE, {11'h000, codes[i]}, 4'hF);
         rd(`ACSS_OFF_SAMPLE, 32'(codes[i]));
         chk("band gap code", 32'(muxPos), 32'(codes[i]));
      end
      // reference enables, one bit each
      xfer(1'b1, `ACSS_OFF_BANDGAP, 16'h0005, 4'hF);
      chk("sixth enable", 32'(bgSixth), 32'h0000_0001);
      chk("half enable", 32'(bgHalf), 32'h0000_0000);
      chk("full enable", 32'(bgFull), 32'h0000_0001);
      xfer(1'b1, `ACSS_OFF_BANDGAP, 16'hFFFF, 4'hF);
      rd(`ACSS_OFF_BANDGAP, 32'h0000_0007);
      xfer(1'b1, `ACSS_OFF_SCAN_HI, 16'hFFFF, 4'hF);
      rd(`ACSS_OFF_SCAN_HI, 32'h0000_7FFF);
      xfer(1'b1, `ACSS_OFF_SCAN_LO, 16'hFFFF, 4'hF);
      rd(`ACSS_OFF_SCAN_LO, 32'h0000_FFFF);
      xfer(1'b1, `ACSS_OFF_HIT_HI, 16'hFFFF, 4'hF);
      rd(`ACSS_OFF_HIT_HI, 32'h0000_0000);
      // scan channels 0, 2, 25, 26, 30 in match-only mode
      xfer(1'b1, `ACSS_OFF_SCAN_HI, 16'h4600, 4'hF);
      xfer(1'b1, `ACSS_OFF_SCAN_LO, 16'h0005, 4'hF);
      xfer(1'b1, `ACSS_OFF_IRQ_MASK, 16'h0007, 4'hF);
      scan();
      rd(`ACSS_OFF_HIT_LO, 32'h0000_0004);
      rd(`ACSS_OFF_HIT_HI, 32'h0000_0000);
      rd(`ACSS_OFF_IRQ_STAT, 32'h0000_0007);
      chk("irq raised", 32'(irq), 32'h0000_0001);
      xfer(1'b1, `ACSS_OFF_IRQ_MASK, 16'h0000, 4'hF);
      chk("irq masked", 32'(irq), 32'h0000_0000);
      xfer(1'b1, `ACSS_OFF_IRQ_MASK, 16'h0007, 4'hF);
      xfer(1'b1, `ACSS_OFF_IRQ_STAT, 16'h0007, 4'hF);
      rd(`ACSS_OFF_IRQ_STAT, 32'h0000_0000);
      chk("irq cleared", 32'(irq), 32'h0000_0000);
      xfer(1'b1, `ACSS_OFF_HIT_LO, 16'h0000, 4'hF);
      rd(`ACSS_OFF_HIT_LO, 32'h0000_0000);
      // write-or-match mode with a slower core
      latency <= 4'h3;
      xfer(1'b1, `ACSS_OFF_CONTROL, 16'h0003, 4'hF);
      scan();
      rd(`ACSS_OFF_HIT_LO, 32'h0000_0005);
      rd(`ACSS_OFF_HIT_HI, 32'h0000_0200);
      xfer(1'b1, `ACSS_OFF_HIT_LO, 16'hFFFF, 4'hF);
      rd(`ACSS_OFF_HIT_LO, 32'h0000_0005);
      xfer(1'b1, `ACSS_OFF_HIT_LO, 16'h0000, 4'hF);
      rd(`ACSS_OFF_HIT_LO, 32'h0000_0000);
      // mode 10 counts matches only, like mode 00
      xfer(1'b1, `ACSS_OFF_HIT_HI, 16'h0000, 4'hF);
      xfer(1'b1, `ACSS_OFF_CONTROL, 16'h0002, 4'hF);
      scan();
      rd(`ACSS_OFF_HIT_LO, 32'h0000_0004);
      rd(`ACSS_OFF_HIT_HI, 32'h0000_0000);
      close_out;
   end
endmodule
